/* fcs_ctrl.sv */
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
module fcs_ctrl
  import fcs_pkg::*;
#(
  parameter int HV_UP_TICKS = 2,
  parameter int PROG_TICKS = 6,
  parameter int SERASE_TICKS = 4000,
  parameter int MERASE_TICKS = 20000,
  parameter int HV_DN_TICKS = 2,
  parameter logic [15:0] EE_BASE = 16'h1700,
  parameter logic [15:0] EE_BYTES = 16'h0100,
  parameter logic [7:0] OPT_VALUE = 8'h00
)(
  input logic REF_CLK,
  input logic RST,
  input logic HSEL,
  input logic [31:0] HADDR,
  input logic [1:0] HTRANS,
  input logic HWRITE,
  input logic [2:0] HSIZE,
  input logic [31:0] HWDATA,
  input logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input logic DBG_CMD_VALID,
  input logic [7:0] DBG_CMD,
  input logic [15:0] DBG_ADDR,
  input logic [7:0] DBG_DATA,
  output logic DBG_ACCEPT,
  output fcs_pkg::fcs_req_t NVM_REQ,
  output logic NVM_HV_EN,
  output logic NVM_PULSE,
  output logic NVM_TICK,
  output logic IRQ
);
  import fcs_pkg::*;

  function automatic logic is_ee(input logic [15:0] a);
    is_ee = (a >= EE_BASE) && (a < EE_BASE + EE_BYTES);
  endfunction

  function automatic logic [15:0] sect_addr(input logic [7:0] c, input logic [15:0] a);
    logic [15:0] sz;
    sz = is_ee(a) ? EE_SECT : FLASH_SECT;
    sect_addr = (c == CMD_SERASE) ? (a & ~(sz - 16'h0001)) : a;
  endfunction

  function automatic logic known_cmd(input logic [7:0] c);
    known_cmd = (c == CMD_PROG) || (c == CMD_SERASE) || (c == CMD_MERASE);
  endfunction

  function automatic logic [15:0] pulse_len(input logic [7:0] c);
    case (c)
      CMD_SERASE: pulse_len = 16'(SERASE_TICKS - 1);
      CMD_MERASE: pulse_len = 16'(MERASE_TICKS - 1);
      default: pulse_len = 16'(PROG_TICKS - 1);
    endcase
  endfunction

  // Bus address phase capture
  logic a_wr_ff;
  logic a_rd_ff;
  logic a_ok_ff;
  logic [12:0] a_idx_ff;
  logic rd_done_ff;
  logic [31:0] hrdata_ff;

  // Register state
  logic [6:0] div_ff;
  logic div_ld_ff;
  logic [7:0] cfg_ff;
  logic [7:0] prot_ff;
  logic [7:0] cmd_ff;
  logic [15:0] addr_ff;
  logic [7:0] data_ff;
  logic acc_err_ff;
  logic ccf_ff;
  logic [IRQ_W-1:0] irq_st_ff;
  logic [IRQ_W-1:0] irq_en_ff;

  // Sequencer state
  fcs_state_t st_ff;
  fcs_state_t nxt_st;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  fcs_req_t req_ff;
  logic tick;

  wire [12:0] h_idx = HADDR[14:2];
  wire addr_take = HSEL & HREADY & HTRANS[1];
  wire h_ok = (HADDR[31:15] == 17'h00000) && (HSIZE == HSIZE_WORD)
    && ((h_idx & IDX_PAGE_MASK) == IDX_PAGE_BASE);
  wire rd_stall = a_rd_ff & ~rd_done_ff;
  wire wr_fire = a_wr_ff & a_ok_ff & HREADY;
  wire [7:0] wd = HWDATA[7:0];

  wire hit_div = a_idx_ff == IDX_CLKDIV;
  wire hit_opt = a_idx_ff == IDX_OPT;
  wire hit_cfg = a_idx_ff == IDX_CFG;
  wire hit_prot = a_idx_ff == IDX_PROT;
  wire hit_stat = a_idx_ff == IDX_STAT;
  wire hit_cmd = a_idx_ff == IDX_CMD;
  wire hit_addrh = a_idx_ff == IDX_ADDRH;
  wire hit_addrl = a_idx_ff == IDX_ADDRL;
  wire hit_data = a_idx_ff == IDX_DATA;
  wire hit_irqst = a_idx_ff == IDX_IRQST;
  wire hit_irqclr = a_idx_ff == IDX_IRQCLR;
  wire hit_irqen = a_idx_ff == IDX_IRQEN;

  wire idle = st_ff == S_IDLE;

  // One write after reset, never while the error flag stands
  wire div_wr = wr_fire & hit_div & ~div_ld_ff & ~acc_err_ff;

  // Bus and debug commands share one launch path; bus wins a tie
  wire bus_cmd = wr_fire & hit_cmd;
  wire bus_ok = div_ld_ff & idle & ~acc_err_ff & known_cmd(wd);
  wire bus_go = bus_cmd & bus_ok;
  wire dbg_take = DBG_CMD_VALID & ~bus_cmd;
  wire dbg_ok = div_ld_ff & idle & ~acc_err_ff & known_cmd(DBG_CMD);
  wire dbg_go = dbg_take & dbg_ok;
  wire start = bus_go | dbg_go;
  wire err_set = (bus_cmd & ~bus_ok) | (dbg_take & ~dbg_ok);
  wire done = (st_ff == S_DOWN) & tick & (cnt_ff == 16'h0000);

  wire stat_wr = wr_fire & hit_stat;
  wire err_clr = stat_wr & wd[ST_ACCERR];
  wire [IRQ_W-1:0] irq_ev = {err_set, done};
  wire [IRQ_W-1:0] irq_clr = (wr_fire & hit_irqclr) ? wd[IRQ_W-1:0] : '0;

  wire [7:0] div_rd = {div_ld_ff, div_ff};
  wire [7:0] stat_rd = {idle, ccf_ff, 1'b0, acc_err_ff, 4'h0};
  wire [7:0] rd_val =
    hit_div ? div_rd :
    hit_opt ? OPT_VALUE :
    hit_cfg ? cfg_ff :
    hit_prot ? prot_ff :
    hit_stat ? stat_rd :
    hit_cmd ? cmd_ff :
    hit_addrh ? addr_ff[15:8] :
    hit_addrl ? addr_ff[7:0] :
    hit_data ? data_ff :
    hit_irqst ? {{(8-IRQ_W){1'b0}}, irq_st_ff} :
    hit_irqen ? {{(8-IRQ_W){1'b0}}, irq_en_ff} :
    8'h00;

  wire fcs_req_t bus_req = '{cmd: wd, addr: sect_addr(wd, addr_ff), data: data_ff,
    eeprom: is_ee(addr_ff)};
  wire fcs_req_t dbg_req = '{cmd: DBG_CMD, addr: sect_addr(DBG_CMD, DBG_ADDR), data: DBG_DATA,
    eeprom: is_ee(DBG_ADDR)};

  // Reads take one wait state so read data always come from a register
  assign HREADYOUT = ~rd_stall;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_ff;
  assign DBG_ACCEPT = dbg_go;
  assign NVM_REQ = req_ff;
  assign NVM_HV_EN = ~st_ff[0];
  assign NVM_PULSE = st_ff[2];
  assign NVM_TICK = tick;
  assign IRQ = |(irq_st_ff & irq_en_ff);

  // Timing clock runs only during a command, so the first tick is a full period
  fcs_tick_div u_div (
    .clk(REF_CLK),
    .rst(RST),
    .en(div_ld_ff & ~idle),
    .pre8(div_ff[PRE8_BIT]),
    .div(div_ff[5:0]),
    .tick(tick)
  );

  // Ramp up, pulse and ramp down are all counted in timing ticks
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      S_IDLE: begin
        if (start) begin
          nxt_st = S_UP;
          nxt_cnt = 16'(HV_UP_TICKS - 1);
        end
      end
      S_UP: begin
        if (tick) begin
          if (cnt_ff == 16'h0000) begin
            nxt_st = S_PULSE;
            nxt_cnt = pulse_len(req_ff.cmd);
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
      end
      S_PULSE: begin
        if (tick) begin
          if (cnt_ff == 16'h0000) begin
            nxt_st = S_DOWN;
            nxt_cnt = 16'(HV_DN_TICKS - 1);
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
      end
      S_DOWN: begin
        if (tick) begin
          if (cnt_ff == 16'h0000) begin
            nxt_st = S_IDLE;
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
      end
      default: begin
        nxt_st = S_IDLE;
        nxt_cnt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      a_wr_ff <= 1'b0;
      a_rd_ff <= 1'b0;
      a_ok_ff <= 1'b0;
      a_idx_ff <= 13'h0000;
    end else if (HREADY) begin
      a_wr_ff <= addr_take & HWRITE;
      a_rd_ff <= addr_take & ~HWRITE;
      a_ok_ff <= h_ok;
      a_idx_ff <= h_idx;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rd_done_ff <= 1'b0;
      hrdata_ff <= 32'h00000000;
    end else begin
      rd_done_ff <= rd_stall;
      if (rd_stall) begin
        hrdata_ff <= a_ok_ff ? {24'h000000, rd_val} : 32'h00000000;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      div_ff <= 7'h00;
      div_ld_ff <= 1'b0;
    end else if (div_wr) begin
      div_ff <= wd[6:0];
      div_ld_ff <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cfg_ff <= 8'h00;
      prot_ff <= PROT_RST;
      addr_ff <= 16'h0000;
      data_ff <= 8'h00;
      irq_en_ff <= '0;
    end else if (wr_fire) begin
      if (hit_cfg) begin
        cfg_ff <= wd & CFG_WMASK;
      end
      if (hit_prot) begin
        prot_ff <= wd;
      end
      if (hit_addrh) begin
        addr_ff[15:8] <= wd;
      end
      if (hit_addrl) begin
        addr_ff[7:0] <= wd;
      end
      if (hit_data) begin
        data_ff <= wd;
      end
      if (hit_irqen) begin
        irq_en_ff <= wd[IRQ_W-1:0];
      end
    end
  end

  // Flags: a new event in the clearing cycle keeps the flag set
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      acc_err_ff <= 1'b0;
      ccf_ff <= 1'b1;
      irq_st_ff <= '0;
    end else begin
      acc_err_ff <= err_set | (acc_err_ff & ~err_clr);
      ccf_ff <= done | (ccf_ff & ~start);
      irq_st_ff <= irq_ev | (irq_st_ff & ~irq_clr);
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cmd_ff <= 8'h00;
      req_ff <= '0;
    end else if (start) begin
      cmd_ff <= bus_go ? wd : DBG_CMD;
      req_ff <= bus_go ? bus_req : dbg_req;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_ff <= S_IDLE;
      cnt_ff <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule

/* fcs_ctrl_assertions.sv */
`timescale 1ns/10ps
module fcs_ctrl_assertions
  import fcs_pkg::*;
(
  input logic REF_CLK,
  input logic RST,
  input logic HSEL,
  input logic [1:0] HTRANS,
  input logic HWRITE,
  input logic HREADY,
  input logic HREADYOUT,
  input logic HRESP,
  input logic DBG_ACCEPT,
  input logic NVM_HV_EN,
  input logic NVM_PULSE,
  input logic NVM_TICK
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence req_rd;
    HSEL && HREADY && HTRANS[1] && !HWRITE;
  endsequence
  sequence req_wr;
    HSEL && HREADY && HTRANS[1] && HWRITE;
  endsequence
  sequence rd_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  chk_resp_okay: assert property (HRESP == 1'b0) else $error("bus response not okay");
  chk_read_wait: assert property (req_rd |=> rd_wait) else $error("read data phase length wrong");
  chk_write_ready: assert property (req_wr |=> HREADYOUT) else $error("write data phase stalled");
  chk_pulse_hv: assert property (NVM_PULSE |-> NVM_HV_EN) else $error("pulse without voltage");
  chk_tick_busy: assert property (NVM_TICK |-> NVM_HV_EN) else $error("tick while idle");
  chk_ramp_up: assert property ($rose(NVM_PULSE) |-> $past(NVM_HV_EN) && $past(NVM_TICK))
    else $error("pulse start off tick or before ramp");
  chk_ramp_down: assert property ($fell(NVM_PULSE) |-> NVM_HV_EN && $past(NVM_TICK))
    else $error("pulse end without ramp down");
  chk_hv_end: assert property ($fell(NVM_HV_EN) |-> $past(NVM_TICK) && !NVM_PULSE)
    else $error("command end off tick");
  chk_dbg_launch: assert property (DBG_ACCEPT |=> NVM_HV_EN) else $error("debug command not started");
endmodule

bind fcs_ctrl fcs_ctrl_assertions fcs_ctrl_assertions_inst (.REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .DBG_ACCEPT(DBG_ACCEPT), .NVM_HV_EN(NVM_HV_EN), .NVM_PULSE(NVM_PULSE), .NVM_TICK(NVM_TICK));

/* fcs_ctrl_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module fcs_ctrl_tb;
  import fcs_pkg::*;
  logic REF_CLK = 0, RST = 1, HSEL = 0, HWRITE = 0, DBG_CMD_VALID = 0;
  logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, ex;
  logic [1:0] HTRANS = 0;
  logic [2:0] HSIZE = HSIZE_WORD;
  logic [7:0] DBG_CMD = 0, DBG_DATA = 0;
  logic [15:0] DBG_ADDR = 0, a;
  logic HREADYOUT, HRESP, DBG_ACCEPT, NVM_HV_EN, NVM_PULSE, NVM_TICK, IRQ;
  fcs_req_t NVM_REQ;
  logic [31:0] exp_q[$];
  logic rd_dp = 0;
  logic [5:0] d;
  logic [7:0] dd;
  int err_total = 0, compares = 0, hv_cyc = 0, ticks = 0, p;
  always #12.5 REF_CLK = ~REF_CLK;
  // Short op counts keep each command to 7 ticks
  fcs_ctrl #(.PROG_TICKS(3), .SERASE_TICKS(3), .MERASE_TICKS(3)) fcs_ctrl_inst (.REF_CLK(REF_CLK), .RST(RST),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .DBG_CMD_VALID(DBG_CMD_VALID),
    .DBG_CMD(DBG_CMD), .DBG_ADDR(DBG_ADDR), .DBG_DATA(DBG_DATA), .DBG_ACCEPT(DBG_ACCEPT), .NVM_REQ(NVM_REQ),
    .NVM_HV_EN(NVM_HV_EN), .NVM_PULSE(NVM_PULSE), .NVM_TICK(NVM_TICK), .IRQ(IRQ));
  // Sampled at the falling edge, where outputs have settled
  always @(negedge REF_CLK) begin
    if (NVM_HV_EN === 1'b1) hv_cyc++;
    if (NVM_TICK === 1'b1) ticks++;
    if (rd_dp && HREADYOUT === 1'b1) begin
      ex = exp_q.pop_front();
      `CHK("hrdata", ex, HRDATA)
    end
  end
  task automatic report_and_stop;
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wait_rdy;
    logic r;
    int n;
    n = 0;
    do begin
      @(negedge REF_CLK);
      r = HREADYOUT;
      @(posedge REF_CLK);
      n++;
    end while (r !== 1'b1 && n < 50);
    if (r !== 1'b1) err_total++;
  endtask
  task automatic bus(input logic [12:0] idx, input logic wr, input logic [7:0] dat);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {17'h0, idx, 2'b00};
    HWRITE <= wr;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= {24'h0, dat};
    rd_dp = !wr;
    wait_rdy();
    rd_dp = 0;
  endtask
  task automatic rd(input logic [12:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(idx, 1'b0, 8'h00);
  endtask
  task automatic run_done;
    int n;
    n = 0;
    do begin
      @(negedge REF_CLK);
      n++;
    end while (!(hv_cyc > 0 && NVM_HV_EN === 1'b0) && n < 3000);
    @(posedge REF_CLK);
    `CHK("hv_cycles", 7 * p, hv_cyc)
    `CHK("ticks", 7, ticks)
  endtask
  initial begin
    #500000;
    err_total++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h30fe8cee));
    repeat (5) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    rd(IDX_PROT, 8'hff);
    rd(IDX_STAT, 8'hc0);
    rd(IDX_CLKDIV, 8'h00);
    rd(IDX_OPT, 8'h00);
    rd(13'h1830, 8'h00);
    bus(IDX_IRQEN, 1'b1, 8'h03);
    bus(IDX_CMD, 1'b1, CMD_PROG);
    rd(IDX_STAT, 8'hd0);
    rd(IDX_IRQST, 8'h02);
    `CHK("irq_set", 1'b1, IRQ)
    bus(IDX_CLKDIV, 1'b1, 8'h41);
    rd(IDX_CLKDIV, 8'h00);
    bus(IDX_STAT, 1'b1, 8'h10);
    bus(IDX_IRQCLR, 1'b1, 8'h02);
    rd(IDX_STAT, 8'hc0);
    `CHK("irq_clr", 1'b0, IRQ)
    // Period of 200 to 264 bus cycles keeps the timing clock inside its band
    d = 6'(24 + $urandom % 9);
    p = (d + 1) * 8;
    bus(IDX_CLKDIV, 1'b1, {2'b01, d});
    bus(IDX_CLKDIV, 1'b1, 8'h05);
    rd(IDX_CLKDIV, {2'b11, d});
    for (int i = 0; i < 2; i++) begin
      dd = 8'($urandom);
      bus(IDX_ADDRL, 1'b1, dd);
      hv_cyc = 0;
      ticks = 0;
      bus(IDX_CMD, 1'b1, i ? CMD_MERASE : CMD_PROG);
      @(negedge REF_CLK);
      `CHK("req_addr", {8'h00, dd}, NVM_REQ.addr)
      `CHK("req_cmd", i ? CMD_MERASE : CMD_PROG, NVM_REQ.cmd)
      @(posedge REF_CLK);
      // Second command while busy must be refused
      if (i) bus(IDX_CMD, 1'b1, CMD_PROG);
      if (i) rd(IDX_STAT, 8'h10);
      run_done();
      rd(IDX_IRQST, i ? 8'h03 : 8'h01);
    end
    bus(IDX_IRQEN, 1'b1, 8'h00);
    rd(IDX_IRQST, 8'h03);
    `CHK("irq_mask", 1'b0, IRQ)
    bus(IDX_STAT, 1'b1, 8'h10);
    bus(IDX_IRQCLR, 1'b1, 8'h03);
    for (int i = 0; i < 2; i++) begin
      a = i ? (16'h8000 | 16'($urandom)) : {8'h17, 8'($urandom)};
      hv_cyc = 0;
      ticks = 0;
      DBG_CMD_VALID <= 1'b1;
      DBG_CMD <= CMD_SERASE;
      DBG_ADDR <= a;
      dd = 8'($urandom);
      DBG_DATA <= dd;
      @(negedge REF_CLK);
      `CHK("dbg_accept", 1'b1, DBG_ACCEPT)
      @(posedge REF_CLK);
      DBG_CMD_VALID <= 1'b0;
      @(negedge REF_CLK);
      `CHK("sector_addr", a & (i ? 16'hfe00 : 16'hfff8), NVM_REQ.addr)
      `CHK("sector_ee", 1'(!i), NVM_REQ.eeprom)
      `CHK("dbg_data", dd, NVM_REQ.data)
      `CHK("dbg_cmd", CMD_SERASE, NVM_REQ.cmd)
      @(posedge REF_CLK);
      run_done();
    end
    report_and_stop();
  end
endmodule

/* fcs_pkg.sv */
package fcs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [12:0] IDX_PAGE_BASE = 13'h1800;
  localparam logic [12:0] IDX_PAGE_MASK = 13'h1fc0;
  localparam logic [12:0] IDX_CLKDIV = 13'h1820;
  localparam logic [12:0] IDX_OPT = 13'h1821;
  localparam logic [12:0] IDX_CFG = 13'h1823;
  localparam logic [12:0] IDX_PROT = 13'h1824;
  localparam logic [12:0] IDX_STAT = 13'h1825;
  localparam logic [12:0] IDX_CMD = 13'h1826;
  localparam logic [12:0] IDX_ADDRH = 13'h1828;
  localparam logic [12:0] IDX_ADDRL = 13'h1829;
  localparam logic [12:0] IDX_DATA = 13'h182a;
  localparam logic [12:0] IDX_IRQST = 13'h182b;
  localparam logic [12:0] IDX_IRQCLR = 13'h182c;
  localparam logic [12:0] IDX_IRQEN = 13'h182d;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Field positions
  localparam int DIV_LD_BIT = 7;
  localparam int PRE8_BIT = 6;
  localparam int ST_CBEF = 7;
  localparam int ST_CCF = 6;
  localparam int ST_ACCERR = 4;
  localparam logic [7:0] CFG_WMASK = 8'h60;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  // Reset value and prescaler wrap count
  localparam logic [7:0] PROT_RST = 8'hff;
  localparam logic [2:0] PRE_LAST = 3'h7;
  // Erase sector sizes in bytes
  localparam logic [15:0] FLASH_SECT = 16'h0200;
  localparam logic [15:0] EE_SECT = 16'h0008;
  typedef enum logic [7:0] {
    CMD_PROG = 8'h01,
    CMD_SERASE = 8'h02,
    CMD_MERASE = 8'h03
  } fcs_cmd_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_UP = 4'b0010,
    S_PULSE = 4'b0100,
    S_DOWN = 4'b1000
  } fcs_state_t;
  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] data;
    logic eeprom;
  } fcs_req_t;
endpackage

/* fcs_tick_div.sv */
`timescale 1ns/10ps
module fcs_tick_div
  import fcs_pkg::*;
(
  input logic clk,
  input logic rst,
  input logic en,
  input logic pre8,
  input logic [5:0] div,
  output logic tick
);
  logic [2:0] pre_ff;
  logic [5:0] div_ff;
  wire pre_wrap = ~pre8 | (pre_ff == PRE_LAST);
  wire div_wrap = (div_ff == div);
  // Counters restart while disabled so each run starts on a whole period
  assign tick = en & pre_wrap & div_wrap;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_ff <= 3'h0;
      div_ff <= 6'h00;
    end else if (!en) begin
      pre_ff <= 3'h0;
      div_ff <= 6'h00;
    end else begin
      pre_ff <= pre_wrap ? 3'h0 : pre_ff + 3'h1;
      if (pre_wrap) begin
        div_ff <= div_wrap ? 6'h00 : div_ff + 6'h01;
      end
    end
  end
endmodule
